// >>> hw/wcbs_dir.sv
// Line directory: valid, modified and tag per cache line, in flip-flops
`timescale 1ns/1ps
module wcbs_dir #(
  parameter int LINES = 2 ** wcbs_pkg::IDX_W
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  wcbs_dir_if.dir   dir
);
  import wcbs_pkg::*;

  logic [LINES-1:0] valid;
  logic [LINES-1:0] modified;
  wcbs_tag_t        tag [LINES];

  assign dir.snp_hit   = valid[dir.snp_idx] && (tag[dir.snp_idx] == dir.snp_tag);
  assign dir.snp_mod   = dir.snp_hit && modified[dir.snp_idx];
  assign dir.cpu_hit   = valid[dir.cpu_idx] && (tag[dir.cpu_idx] == dir.cpu_tag);
  assign dir.cpu_dirty = modified[dir.cpu_idx];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid    <= '0;
      modified <= '0;
      for (int i = 0; i < LINES; i++) begin
        tag[i] <= '0;
      end
    end else begin
      if (dir.fill_en) begin
        valid[dir.cpu_idx]    <= 1'b1;
        tag[dir.cpu_idx]      <= dir.cpu_tag;
        modified[dir.cpu_idx] <= 1'b0;
      end
      if (dir.clean_en) begin
        modified[dir.clean_idx] <= 1'b0;
      end
      // A new write hit wins over a writeback finishing on the same line
      if (dir.dirty_en) begin
        modified[dir.cpu_idx] <= 1'b1;
      end
    end
  end
endmodule

// >>> hw/wcbs_dir_if.sv
// Lookup and update signals between the bus controller and the line directory
`timescale 1ns/1ps
interface wcbs_dir_if;
  wcbs_pkg::wcbs_idx_t snp_idx;
  wcbs_pkg::wcbs_tag_t snp_tag;
  logic                snp_hit;
  logic                snp_mod;
  wcbs_pkg::wcbs_idx_t cpu_idx;
  wcbs_pkg::wcbs_tag_t cpu_tag;
  logic                cpu_hit;
  logic                cpu_dirty;
  logic                fill_en;
  logic                dirty_en;
  logic                clean_en;
  wcbs_pkg::wcbs_idx_t clean_idx;

  modport ctl (output snp_idx, snp_tag, cpu_idx, cpu_tag, fill_en, dirty_en, clean_en,
               clean_idx, input snp_hit, snp_mod, cpu_hit, cpu_dirty);
  modport dir (input snp_idx, snp_tag, cpu_idx, cpu_tag, fill_en, dirty_en, clean_en,
               clean_idx, output snp_hit, snp_mod, cpu_hit, cpu_dirty);
endinterface

// >>> hw/wcbs_pkg.sv
// Shared constants and types for the writeback cache bus signalling block
package wcbs_pkg;
  localparam int ADDR_W = 16;
  localparam int OFS_W  = 4;
  localparam int IDX_W  = 2;
  localparam int TAG_W  = ADDR_W - OFS_W - IDX_W;
  localparam int CNT_W  = 2;

  // Index of the fourth and last transfer of a line burst
  localparam logic [CNT_W-1:0] LAST_BEAT   = 2'h3;
  localparam logic             RST_WB_MODE = 1'b0;
  localparam logic             PIN_IDLE_N  = 1'b1;

  typedef logic [ADDR_W-1:0] wcbs_addr_t;
  typedef logic [IDX_W-1:0]  wcbs_idx_t;
  typedef logic [TAG_W-1:0]  wcbs_tag_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_ADDR    = 3'h1,
    ST_DATA    = 3'h3,
    ST_WB_ADDR = 3'h4,
    ST_WB_DATA = 3'h6
  } wcbs_state_t;
endpackage

// >>> hw/wcbs_top.sv
// Bus-side signalling of the internal writeback cache
// What this block does
// - Linefill intent low on reads wanting a line; does not force final high.
// - Single transfer with grant sampled high: burst final low, one transfer.
// - Copyback select is caught at reset release to choose writeback or writethrough.
// - Snoop match, snoop modified and linefill intent are always driven.
// - Writethrough mode holds snoop match and snoop modified high.
// - Linefill intent toggles for reads and stays high on every write.
// - Snoop hitting a modified line drives snoop modified low.
// - Snoop modified stays low until the line's writeback completes.
// - Release snoop modified after the last writeback ready, before next strobe.
`timescale 1ns/1ps
module wcbs_top (
  input  wire logic                 REF_CLK_IN,
  input  wire logic                 RESET_IN,
  input  wire logic                 COPYBACK_SELECT_IN,
  input  wire logic                 CPU_REQ_IN,
  input  wire logic                 CPU_WRITE_IN,
  input  wire logic                 CPU_CACHE_IN,
  input  wire wcbs_pkg::wcbs_addr_t CPU_ADDR_IN,
  input  wire logic                 SNOOP_STROBE_IN,
  input  wire wcbs_pkg::wcbs_addr_t SNOOP_ADDR_IN,
  input  wire logic                 CACHEABLE_GRANT_N_IN,
  input  wire logic                 BURST_DONE_N_IN,
  input  wire logic                 NONBURST_DONE_N_IN,
  output logic                      CPU_DONE_OUT,
  output logic                      ADDR_STROBE_N_OUT,
  output wcbs_pkg::wcbs_addr_t      BUS_ADDR_OUT,
  output logic                      BUS_WRITE_OUT,
  output logic                      LINEFILL_INTENT_N_OUT,
  output logic                      BURST_FINAL_N_OUT,
  output logic                      SNOOP_MATCH_N_OUT,
  output logic                      SNOOP_MODIFIED_N_OUT,
  output logic                      WB_MODE_OUT
);
  import wcbs_pkg::*;

  wcbs_state_t       state;
  wcbs_state_t       next_state;
  logic              caught;
  logic              wb_mode;
  logic              wb_pending;
  wcbs_addr_t        wb_addr;
  logic [CNT_W-1:0]  beat_cnt;
  logic              filling;

  wcbs_dir_if dir_bus ();

  wcbs_dir #(
    .LINES (2 ** IDX_W)
  ) u_dir (
    .clk_in (REF_CLK_IN),
    .rst_in (RESET_IN),
    .dir    (dir_bus.dir)
  );

  wire              idle        = (state == ST_IDLE);
  wire              in_data     = (state == ST_DATA) || (state == ST_WB_DATA);
  wire              bus_ready   = !BURST_DONE_N_IN || !NONBURST_DONE_N_IN;
  wire              beat_end    = in_data && bus_ready;
  wire              last_beat   = beat_end && !BURST_FINAL_N_OUT;
  wire              snoop_ev    = SNOOP_STROBE_IN && wb_mode && caught;
  wire              snoop_dirty = snoop_ev && dir_bus.snp_mod;
  wire              wb_take     = idle && wb_pending;
  // The request still stands in the done cycle, so it must not be taken again there
  wire              cpu_take    = idle && caught && CPU_REQ_IN && !wb_pending && !CPU_DONE_OUT;
  wire              local_write = CPU_WRITE_IN && wb_mode && dir_bus.cpu_hit;
  wire              bus_take    = cpu_take && !local_write;
  // A dirty line at the target index is never replaced, so no fill is asked for
  wire              want_fill   = !CPU_WRITE_IN && CPU_CACHE_IN && !dir_bus.cpu_dirty;
  // Grant is sampled in the strobe cycle; a burst only if the line is granted
  wire              cpu_burst   = !LINEFILL_INTENT_N_OUT && !CACHEABLE_GRANT_N_IN;
  wire [CNT_W-1:0]  beat_next   = beat_cnt + 2'h1;
  wire              next_strobe = (next_state == ST_ADDR) || (next_state == ST_WB_ADDR);
  wire wcbs_addr_t  cpu_addr    = idle ? CPU_ADDR_IN : BUS_ADDR_OUT;

  assign dir_bus.snp_idx   = SNOOP_ADDR_IN[OFS_W +: IDX_W];
  assign dir_bus.snp_tag   = SNOOP_ADDR_IN[ADDR_W-1 -: TAG_W];
  assign dir_bus.cpu_idx   = cpu_addr[OFS_W +: IDX_W];
  assign dir_bus.cpu_tag   = cpu_addr[ADDR_W-1 -: TAG_W];
  assign dir_bus.fill_en   = (state == ST_DATA) && last_beat && filling;
  assign dir_bus.dirty_en  = cpu_take && local_write;
  assign dir_bus.clean_en  = (state == ST_WB_DATA) && last_beat;
  assign dir_bus.clean_idx = BUS_ADDR_OUT[OFS_W +: IDX_W];
  assign WB_MODE_OUT       = wb_mode;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (wb_take) begin
          next_state = ST_WB_ADDR;
        end else if (bus_take) begin
          next_state = ST_ADDR;
        end
      end
      ST_ADDR:    next_state = ST_DATA;
      ST_DATA:    next_state = last_beat ? ST_IDLE : ST_DATA;
      ST_WB_ADDR: next_state = ST_WB_DATA;
      ST_WB_DATA: next_state = last_beat ? ST_IDLE : ST_WB_DATA;
      default:    next_state = ST_IDLE;
    endcase
  end

  // Mode is caught on the first edge after reset release
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      caught  <= 1'b0;
      wb_mode <= RST_WB_MODE;
    end else if (!caught) begin
      caught  <= 1'b1;
      wb_mode <= COPYBACK_SELECT_IN;
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state             <= ST_IDLE;
      ADDR_STROBE_N_OUT <= PIN_IDLE_N;
      BUS_ADDR_OUT      <= '0;
      BUS_WRITE_OUT     <= 1'b0;
      CPU_DONE_OUT      <= 1'b0;
    end else begin
      state             <= next_state;
      ADDR_STROBE_N_OUT <= !next_strobe;
      CPU_DONE_OUT      <= ((state == ST_DATA) && last_beat) || dir_bus.dirty_en;
      if (wb_take) begin
        BUS_ADDR_OUT  <= wb_addr;
        BUS_WRITE_OUT <= 1'b1;
      end else if (bus_take) begin
        BUS_ADDR_OUT  <= CPU_ADDR_IN;
        BUS_WRITE_OUT <= CPU_WRITE_IN;
      end
    end
  end

  // Intent, burst count and burst final for each bus cycle
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      LINEFILL_INTENT_N_OUT <= PIN_IDLE_N;
      BURST_FINAL_N_OUT     <= PIN_IDLE_N;
      beat_cnt              <= '0;
      filling               <= 1'b0;
    end else begin
      if (bus_take && !wb_take) begin
        LINEFILL_INTENT_N_OUT <= !want_fill;
      end else if (wb_take || last_beat) begin
        LINEFILL_INTENT_N_OUT <= PIN_IDLE_N;
      end
      if (state == ST_ADDR) begin
        beat_cnt          <= '0;
        filling           <= cpu_burst;
        BURST_FINAL_N_OUT <= cpu_burst;
      end else if (state == ST_WB_ADDR) begin
        beat_cnt          <= '0;
        filling           <= 1'b0;
        BURST_FINAL_N_OUT <= PIN_IDLE_N;
      end else if (last_beat) begin
        BURST_FINAL_N_OUT <= PIN_IDLE_N;
      end else if (beat_end) begin
        beat_cnt          <= beat_next;
        BURST_FINAL_N_OUT <= (beat_next != LAST_BEAT);
      end
    end
  end

  // Snoop answers and the pending writeback they cause
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      SNOOP_MATCH_N_OUT    <= PIN_IDLE_N;
      SNOOP_MODIFIED_N_OUT <= PIN_IDLE_N;
      wb_pending           <= 1'b0;
      wb_addr              <= '0;
    end else begin
      if (snoop_ev) begin
        SNOOP_MATCH_N_OUT <= !dir_bus.snp_hit;
      end
      if (snoop_dirty) begin
        SNOOP_MODIFIED_N_OUT <= 1'b0;
        wb_pending           <= 1'b1;
        wb_addr              <= {SNOOP_ADDR_IN[ADDR_W-1:OFS_W], {OFS_W{1'b0}}};
      end else begin
        if (wb_take) begin
          wb_pending <= 1'b0;
        end
        if (dir_bus.clean_en && !wb_pending) begin
          SNOOP_MODIFIED_N_OUT <= PIN_IDLE_N;
        end
      end
    end
  end

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence wb_final_beat;
    (state == ST_WB_DATA) && last_beat && !snoop_dirty && !wb_pending;
  endsequence

  sequence single_grant_refused;
    (state == ST_ADDR) && !CACHEABLE_GRANT_N_IN == 1'b0;
  endsequence

  wt_snoop_quiet_a: assert property (caught && !wb_mode |-> ##1
    SNOOP_MATCH_N_OUT && SNOOP_MODIFIED_N_OUT) else $error("snoop pins low in writethrough");
  write_no_intent_a: assert property (!ADDR_STROBE_N_OUT && BUS_WRITE_OUT |->
    LINEFILL_INTENT_N_OUT) else $error("linefill intent low on a write");
  snoop_modified_n_assert_a: assert property (snoop_dirty |=> !SNOOP_MODIFIED_N_OUT)
    else $error("snoop modified not asserted on dirty hit");
  snoop_modified_n_hold_a: assert property ($rose(SNOOP_MODIFIED_N_OUT) |->
    $past((state == ST_WB_DATA) && last_beat)) else $error("snoop modified released early");
  snoop_modified_n_release_a: assert property (wb_final_beat |=> SNOOP_MODIFIED_N_OUT &&
    ADDR_STROBE_N_OUT) else $error("snoop modified not released before next strobe");
  single_final_a: assert property (single_grant_refused |=> !BURST_FINAL_N_OUT)
    else $error("single transfer without burst final");
  intent_no_force_a: assert property ((state == ST_ADDR) && cpu_burst |=>
    BURST_FINAL_N_OUT [*1] ##0 (state == ST_DATA)) else $error("granted linefill cut short");
  mode_latch_a: assert property ($rose(caught) |->
    wb_mode == $past(COPYBACK_SELECT_IN))
    else $error("cache mode not taken from select at reset release");
  wb_match_a: assert property (snoop_ev |=>
    SNOOP_MATCH_N_OUT == !$past(dir_bus.snp_hit))
    else $error("snoop match does not follow directory hit");
  burst_len_a: assert property ((state == ST_DATA) && filling && beat_end &&
    (beat_cnt == 2'h2) |=> !BURST_FINAL_N_OUT)
    else $error("burst final not on fourth transfer");
endmodule

// >>> sim/test_writeback_cache_bus_signalling.sv
// Self-checking bench for the writeback cache bus signalling block
`timescale 1ns/1ps
module test_writeback_cache_bus_signalling;
  import wcbs_pkg::*;
  localparam wcbs_addr_t A = 16'h1230;
  localparam wcbs_addr_t B = 16'h5230;
  logic       clk, rst, sel, req, wr, cch, snp, grant_en, slow, use_nb;
  logic       done, as_n, bus_wr, int_n, fin_n, hit_n, mod_n, wbm;
  logic       grant_n, bdone_n, nbdone_n, int_at, wr_at, mod_at;
  wcbs_addr_t cpu_addr, snp_addr, bus_addr;
  logic [2:0] beats, finals;
  int         fail_count, compares, strobes;

  wcbs_top i_wcbs_top (.REF_CLK_IN(clk), .RESET_IN(rst), .COPYBACK_SELECT_IN(sel),
    .CPU_REQ_IN(req), .CPU_WRITE_IN(wr), .CPU_CACHE_IN(cch), .CPU_ADDR_IN(cpu_addr),
    .SNOOP_STROBE_IN(snp), .SNOOP_ADDR_IN(snp_addr), .CACHEABLE_GRANT_N_IN(grant_n),
    .BURST_DONE_N_IN(bdone_n), .NONBURST_DONE_N_IN(nbdone_n), .CPU_DONE_OUT(done),
    .ADDR_STROBE_N_OUT(as_n), .BUS_ADDR_OUT(bus_addr), .BUS_WRITE_OUT(bus_wr),
    .LINEFILL_INTENT_N_OUT(int_n), .BURST_FINAL_N_OUT(fin_n), .SNOOP_MATCH_N_OUT(hit_n),
    .SNOOP_MODIFIED_N_OUT(mod_n), .WB_MODE_OUT(wbm));
  wcbs_sys_model i_wcbs_sys_model (.clk_in(clk), .rst_in(rst), .strobe_n_in(as_n),
    .final_n_in(fin_n), .grant_en_in(grant_en), .slow_in(slow), .use_nb_in(use_nb),
    .grant_n_out(grant_n), .burst_done_n_out(bdone_n), .nonburst_done_n_out(nbdone_n),
    .beats_out(beats), .finals_out(finals));

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // Records what the bus showed in each strobe cycle
  always @(posedge clk) begin
    if (as_n === 1'h0) begin
      strobes++;
      int_at = int_n;
      wr_at = bus_wr;
      mod_at = mod_n;
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic do_reset(input logic mode);
    rst <= 1'h1;
    sel <= mode;
    req <= 1'h0;
    snp <= 1'h0;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    check("mode", wbm, mode);
  endtask

  task automatic op(input logic w, c, input wcbs_addr_t a, input logic g, nb, sl);
    int i;
    strobes = 0;
    @(posedge clk);
    req <= 1'h1;
    wr <= w;
    cch <= c;
    cpu_addr <= a;
    grant_en <= g;
    use_nb <= nb;
    slow <= sl;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'h1) break;
    end
    check("done", done, 1);
    @(posedge clk);
    req <= 1'h0;
  endtask

  task automatic bus_case(input logic w, c, input wcbs_addr_t a, input logic g, nb, sl,
                          input int eb, input logic ei);
    op(w, c, a, g, nb, sl);
    check("strobes", strobes, 1);
    check("intent", int_at, ei);
    check("write", wr_at, w);
    check("beats", beats, eb);
    check("finals", finals, 1);
  endtask

  task automatic snoop(input wcbs_addr_t a);
    @(posedge clk);
    snp <= 1'h1;
    snp_addr <= a;
    @(posedge clk);
    snp <= 1'h0;
    #1;
    check("driven", $isunknown({hit_n, mod_n, int_n}), 0);
  endtask

  task automatic test_wt();
    do_reset(1'h0);
    bus_case(1'h0, 1'h1, A, 1'h1, 1'h0, 1'h0, 4, 1'h0);
    bus_case(1'h0, 1'h1, B, 1'h0, 1'h1, 1'h1, 1, 1'h0);
    bus_case(1'h0, 1'h0, B, 1'h1, 1'h0, 1'h0, 1, 1'h1);
    bus_case(1'h1, 1'h0, A, 1'h1, 1'h0, 1'h0, 1, 1'h1);
    snoop(A);
    check("match", hit_n, 1);
    check("modified", mod_n, 1);
  endtask

  task automatic test_wb();
    int i;
    do_reset(1'h1);
    bus_case(1'h0, 1'h1, A, 1'h1, 1'h0, 1'h1, 4, 1'h0);
    snoop(A);
    check("match", hit_n, 0);
    check("modified", mod_n, 1);
    snoop(B);
    check("match", hit_n, 1);
    op(1'h1, 1'h0, A, 1'h1, 1'h1, 1'h0);
    check("strobes", strobes, 0);
    bus_case(1'h0, 1'h1, B, 1'h1, 1'h0, 1'h0, 1, 1'h1);
    snoop(A);
    check("modified", mod_n, 0);
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      #1;
      if (as_n === 1'h0) break;
    end
    check("wb strobe", as_n, 0);
    check("wb write", bus_wr, 1);
    check("wb addr", bus_addr, {A[15:4], 4'h0});
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if (beats === 3'h4) break;
      check("held", mod_n, 0);
    end
    check("wb beats", beats, 4);
    bus_case(1'h0, 1'h0, B, 1'h1, 1'h0, 1'h0, 1, 1'h1);
    check("released", mod_at, 1);
  endtask

  initial begin
    fail_count = 0;
    compares = 0;
    strobes = 0;
    wr <= 1'h0;
    cch <= 1'h0;
    cpu_addr <= 16'h0000;
    snp_addr <= 16'h0000;
    grant_en <= 1'h1;
    slow <= 1'h0;
    use_nb <= 1'h0;
    test_wt();
    test_wb();
    end_of_test();
  end

  initial begin
    #(25 * 5000);
    fail_count++;
    end_of_test();
  end
endmodule

// >>> sim/wcbs_sys_model.sv
// Behavioural system memory controller answering the cache bus cycles
`timescale 1ns/1ps
module wcbs_sys_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       strobe_n_in,
  input  wire logic       final_n_in,
  input  wire logic       grant_en_in,
  input  wire logic       slow_in,
  input  wire logic       use_nb_in,
  output logic            grant_n_out,
  output logic            burst_done_n_out,
  output logic            nonburst_done_n_out,
  output logic [2:0]      beats_out,
  output logic [2:0]      finals_out
);
  logic act;
  logic tick;
  logic rdy;
  // Grant only counts in the strobe cycle; elsewhere it shows the opposite level
  assign grant_n_out = strobe_n_in ? grant_en_in : ~grant_en_in;
  assign rdy = act & (~slow_in | tick);
  assign burst_done_n_out = ~(rdy & ~use_nb_in);
  assign nonburst_done_n_out = ~(rdy & use_nb_in);
  // Snoop modified is never consulted, so any legal release clock is accepted
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      act <= 1'h0;
      tick <= 1'h0;
      beats_out <= 3'h0;
      finals_out <= 3'h0;
    end else begin
      tick <= ~tick;
      if (!strobe_n_in) begin
        act <= 1'h1;
        beats_out <= 3'h0;
        finals_out <= 3'h0;
      end else if (rdy) begin
        beats_out <= beats_out + 3'h1;
        finals_out <= finals_out + {2'h0, ~final_n_in};
        if (!final_n_in) begin
          act <= 1'h0;
        end
      end
    end
  end
endmodule
